// ===== bench/mfs_pos_model.sv
// Engine position source standing in for the position tracker
`timescale 1ns/1ps
module mfs_pos_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        slow,
	output logic      [15:0] pos,
	output logic             posValid
);
	logic half;
	// ==========================================================
	// Position advances one tick a cycle, or one every two when slow
	always_ff @(posedge mclk) begin
		if (rst) begin
			pos <= 16'h0000;
			posValid <= 1'b0;
			half <= 1'b0;
		end else if (!run) begin
			// Stale position is kept, but flagged unusable
			posValid <= 1'b0;
			half <= 1'b0;
		end else begin
			posValid <= 1'b1;
			half <= slow && !half;
			if (posValid && !half) begin
				pos <= (pos == mfs_pkg::CYCLE_CAT - 16'h0001) ? 16'h0000 : pos + 16'h0001;
			end
		end
	end
endmodule : mfs_pos_model

// ===== bench/mfs_sched_monitor.sv
// Port-level checker of the scheduler, bound to its top module
`timescale 1ns/1ps
module mfs_sched_monitor (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] enginePos,
	input wire logic        enginePosValid,
	input wire logic [31:0] unlockToken,
	input wire logic        channelSwitchStrobe,
	input wire logic        pulseOutCh1,
	input wire logic        pulseOutCh2,
	input wire logic        pulseOutCh3,
	input wire logic        pulseOutCh4
);
	// ==========================================================
	// Shadow of the settings software wrote
	logic [3:0]  outs;
	logic [3:0]  mainOn_ff;
	logic [15:0] swAng_ff [4];
	logic [1:0]  cur_ff;
	logic [4:0]  quiet_ff;
	logic        wr;
	logic        bad;
	logic        unmapped;
	assign outs = {pulseOutCh4, pulseOutCh3, pulseOutCh2, pulseOutCh1};
	assign wr = psel && penable && pready && pwrite && paddr[11:8] == 4'h0;
	assign bad = unlockToken != mfs_pkg::UNLOCK_TOKEN;
	assign unmapped = !(paddr[11:8] == 4'h0 && paddr[5:2] < 4'hC || paddr[11:2] == 10'h040);
	always_ff @(posedge mclk) begin
		if (rst) begin
			mainOn_ff <= 4'h0;
			cur_ff <= 2'h0;
			quiet_ff <= 5'h00;
			swAng_ff <= '{default: 16'h0000};
		end else begin
			if (channelSwitchStrobe) cur_ff <= cur_ff + 2'h1;
			// Reload after a control write takes a while, so wait it out
			if (wr && paddr[5:2] == 4'h0) quiet_ff <= 5'h00;
			else if (quiet_ff != 5'h1F) quiet_ff <= quiet_ff + 5'h01;
			if (wr && paddr[5:2] == 4'h0) mainOn_ff[paddr[7:6]] <= pwdata[0];
			if (wr && paddr[5:2] == 4'hB) swAng_ff[paddr[7:6]] <= pwdata[15:0];
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence accessStart;
		psel && !penable ##1 psel && penable;
	endsequence
	chk_strobe_single: assert property (channelSwitchStrobe |=> !channelSwitchStrobe)
		else $error("strobe too long");
	chk_strobe_at_angle: assert property (channelSwitchStrobe |-> $past(enginePosValid)
		&& $past(enginePos) == swAng_ff[cur_ff]) else $error("strobe off angle");
	chk_switch_cuts: assert property (channelSwitchStrobe |=> outs == 4'h0)
		else $error("pulse kept over switch");
	chk_lock_quiet: assert property (bad && $past(bad) |-> outs == 4'h0)
		else $error("output while locked");
	chk_main_gate: assert property (quiet_ff == 5'h1F |-> (outs & ~mainOn_ff) == 4'h0)
		else $error("output with main off");
	chk_write_nowait: assert property (accessStart ##0 pwrite |-> pready)
		else $error("write waited");
	chk_read_bounded: assert property (accessStart ##0 !pwrite |-> ##[0:14] pready)
		else $error("read too slow");
	chk_unmapped_err: assert property (psel && penable && pready |-> pslverr == unmapped)
		else $error("wrong error answer");
endmodule : mfs_sched_monitor

bind mfs_scheduler mfs_sched_monitor u_mon (.mclk(mclk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .enginePos(enginePos), .enginePosValid(enginePosValid),
	.unlockToken(unlockToken), .channelSwitchStrobe(channelSwitchStrobe),
	.pulseOutCh1(pulseOutCh1), .pulseOutCh2(pulseOutCh2), .pulseOutCh3(pulseOutCh3),
	.pulseOutCh4(pulseOutCh4));

// ===== bench/mfs_scheduler_tb_top.sv
// Self-checking bench of the multi-pulse fuel scheduler
`timescale 1ns/1ps
module mfs_scheduler_tb_top;
	localparam int CYC = int'(mfs_pkg::CYCLE_CAT);
	logic        mclk, rst, psel, penable, pwrite, pready, pslverr, posValid, run, slow, strobe, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, tokenSrc, token, r;
	logic [15:0] pos;
	logic [3:0]  outs, outsPrev;
	logic [31:0] cfg [4][12];
	logic [4:0]  en [4];
	int          expR [4][$], expW [4][$], gotR [4][$], gotW [4][$];
	int          strobes, err_count, n_tests;
	// Windows keep software spacing and order, wrapping through ch3
	int          st [4] = '{750, 1550, 2250, 100};
	int          sw [4] = '{1200, 1900, 2600, 400};

	always #10 mclk = ~mclk;
	always @(posedge mclk) token <= tokenSrc;
	mfs_pos_model u_pos (.mclk(mclk), .rst(rst), .run(run), .slow(slow), .pos(pos),
		.posValid(posValid));
	mfs_scheduler DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enginePos(pos), .enginePosValid(posValid), .unlockToken(token),
		.channelSwitchStrobe(strobe), .pulseOutCh1(outs[0]), .pulseOutCh2(outs[1]),
		.pulseOutCh3(outs[2]), .pulseOutCh4(outs[3]));

	// ==========================================================
	// Helpers
	function automatic int wrap(input int p);
		return (p % CYC + CYC) % CYC;
	endfunction : wrap
	function automatic logic [31:0] rnd(input int lo, input int hi);
		return 32'(lo) + $urandom % 32'(hi - lo + 1);
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40) chk(32'h0, 32'h1, "bus hang");
	endtask : apb
	task automatic add(input int c, input int t, input logic [31:0] w);
		expR[c].push_back(wrap(t + 2));
		expW[c].push_back(int'(w[17:0]));
	endtask : add
	task automatic build(input int c);
		int a;
		a = st[c] + 4 + int'(cfg[c][6][17:0]) + int'(cfg[c][7][23:0]);
		if (en[c][0]) begin
			if (en[c][1]) add(c, st[c] - int'(cfg[c][2][15:0]), cfg[c][4]);
			if (en[c][2]) add(c, st[c] - int'(cfg[c][3][15:0]), cfg[c][5]);
			add(c, st[c], cfg[c][6]);
			if (en[c][3]) add(c, a - 2, cfg[c][8]);
			if (en[c][3] && en[c][4])
				add(c, a + int'(cfg[c][8][17:0] + cfg[c][9][23:0]), cfg[c][10]);
		end
	endtask : build
	task automatic verify(input int reps, input int ns, input bit full);
		chk(32'(strobes), 32'(ns), "strobes");
		for (int c = 0; c < 4; c++) begin
			chk(32'(gotR[c].size()), 32'(reps * expR[c].size()), "pulses");
			for (int i = 0; full && i < gotW[c].size() && i < reps * expR[c].size(); i++) begin
				chk(32'(gotR[c][i]), 32'(expR[c][i % expR[c].size()]), "rise");
				chk(32'(gotW[c][i]), 32'(expW[c][i % expR[c].size()]), "width");
			end
			gotR[c] = {};
			gotW[c] = {};
		end
		strobes = 0;
	endtask : verify
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	always @(posedge mclk) begin
		if (strobe === 1'b1) strobes++;
		for (int k = 0; k < 4; k++) begin
			if (outs[k] === 1'b1 && outsPrev[k] === 1'b0) gotR[k].push_back(int'(pos));
			if (outs[k] === 1'b0 && outsPrev[k] === 1'b1)
				gotW[k].push_back(wrap(int'(pos) - gotR[k][$]));
		end
		outsPrev <= outs;
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hFA98));
		{mclk, rst, psel, penable, pwrite, run, slow} = 7'h20;
		{paddr, pwdata, tokenSrc} = '0;
		{strobes, err_count, n_tests} = '0;
		en = '{5'h1F, 5'h17, 5'h1E, 5'($urandom)};
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, 12'h040, 32'h0);
		chk(r, mfs_pkg::RST_WORD, "reset ctrl");
		apb(1'b1, 12'h0F0, 32'h1);
		chk(32'(e), 32'h1, "unmapped write");
		apb(1'b0, 12'h200, 32'h0);
		chk({r[30:0], e}, 32'h1, "unmapped read");
		for (int c = 0; c < 4; c++) begin
			cfg[c][0] = 32'(en[c]);
			cfg[c][1] = 32'(st[c]);
			cfg[c][2] = rnd(200, 300);
			cfg[c][3] = rnd(60, 150);
			// Upper junk bits check the truncation of times
			for (int k = 4; k < 11; k++) begin
				if (k == 7 || k == 9) cfg[c][k] = ($urandom << 24) | rnd(5, 30);
				else cfg[c][k] = ($urandom << 18) | rnd(10, 40);
			end
			cfg[c][11] = 32'(sw[c]);
			build(c);
			for (int k = 0; k < 12; k++) apb(1'b1, 12'(c * 64 + k * 4), cfg[c][k]);
			for (int k = 0; k < 12; k++) begin
				apb(1'b0, 12'(c * 64 + k * 4), 32'h0);
				chk(r, cfg[c][k], "readback");
			end
		end
		$display("test registers done");
		tokenSrc <= mfs_pkg::UNLOCK_TOKEN;
		apb(1'b0, mfs_pkg::STATUS_OFS, 32'h0);
		chk(32'(r[mfs_pkg::ST_UNLOCK]), 32'h1, "unlocked");
		run <= 1'b1;
		repeat (2 * CYC + 440) @(posedge mclk);
		run <= 1'b0;
		verify(2, 8, 1'b1);
		$display("test fast engine done");
		tokenSrc <= 32'h0;
		slow <= 1'b1;
		// Let the stop take effect before the engine runs again
		@(posedge mclk);
		run <= 1'b1;
		repeat (2 * CYC) @(posedge mclk);
		verify(0, 4, 1'b0);
		$display("test locked done");
		tokenSrc <= mfs_pkg::UNLOCK_TOKEN;
		repeat (2 * CYC) @(posedge mclk);
		verify(1, 4, 1'b0);
		$display("test slow engine done");
		end_of_test();
	end

	initial begin
		#(30000 * 20);
		chk(32'h0, 32'h1, "timeout");
		end_of_test();
	end
endmodule : mfs_scheduler_tb_top

// ===== hw/mfs_cfg_mem.sv
// Per-channel settings store, one write port, one registered read port
`timescale 1ns/1ps
module mfs_cfg_mem (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       we,
	input  wire logic [mfs_pkg::MEM_AW-1:0] waddr,
	input  wire logic [mfs_pkg::DATA_W-1:0] wdata,
	input  wire logic                       re,
	input  wire logic [mfs_pkg::MEM_AW-1:0] raddr,
	output logic      [mfs_pkg::DATA_W-1:0] rdata
);
	typedef struct packed {
		logic [mfs_pkg::MEM_DEPTH-1:0][mfs_pkg::DATA_W-1:0] mem;
		logic [mfs_pkg::DATA_W-1:0]                         rdata;
	} mfs_mem_state_t;

	mfs_mem_state_t st_ff;
	mfs_mem_state_t nxt_st;

	// ==========================================================
	// Storage
	// Cleared at reset so every enable starts false
	always_comb begin
		nxt_st = st_ff;
		if (we) begin
			nxt_st.mem[waddr] = wdata;
		end
		if (re) begin
			nxt_st.rdata = st_ff.mem[raddr];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
endmodule : mfs_cfg_mem

// ===== hw/mfs_pkg.sv
// Shared constants, field layouts and types of the multi-pulse fuel scheduler
package mfs_pkg;

	// ==========================================================
	// Widths
	localparam int NUM_CH    = 4;
	localparam int CH_W      = 2;
	localparam int POS_W     = 16;
	localparam int DUR_W     = 18;
	localparam int DLY_W     = 24;
	localparam int CNT_W     = 24;
	localparam int DATA_W    = 32;
	localparam int ADDR_W    = 12;
	localparam int MEM_AW    = 6;
	localparam int MEM_DEPTH = 64;
	localparam int IDX_W     = 4;
	localparam int NUM_TMR   = 3;

	// ==========================================================
	// Register map: channel word at byte {ch, idx, 2'b00}
	localparam logic [IDX_W-1:0] IDX_CTRL      = 4'h0;
	localparam logic [IDX_W-1:0] IDX_MAIN_ANG  = 4'h1;
	localparam logic [IDX_W-1:0] IDX_PILOT_ADV = 4'h2;
	localparam logic [IDX_W-1:0] IDX_PRE_ADV   = 4'h3;
	localparam logic [IDX_W-1:0] IDX_PILOT_DUR = 4'h4;
	localparam logic [IDX_W-1:0] IDX_PRE_DUR   = 4'h5;
	localparam logic [IDX_W-1:0] IDX_MAIN_DUR  = 4'h6;
	localparam logic [IDX_W-1:0] IDX_AFTER_DLY = 4'h7;
	localparam logic [IDX_W-1:0] IDX_AFTER_DUR = 4'h8;
	localparam logic [IDX_W-1:0] IDX_POST_DLY  = 4'h9;
	localparam logic [IDX_W-1:0] IDX_POST_DUR  = 4'hA;
	localparam logic [IDX_W-1:0] IDX_SWITCH    = 4'hB;
	localparam logic [IDX_W-1:0] IDX_COUNT     = 4'hC;
	localparam logic [ADDR_W-1:0] STATUS_OFS   = 12'h100;
	localparam logic [DATA_W-1:0] RST_WORD     = 32'h0000_0000;

	// ==========================================================
	// Field positions
	localparam int BIT_MAIN_EN  = 0;
	localparam int BIT_PILOT_EN = 1;
	localparam int BIT_PRE_EN   = 2;
	localparam int BIT_AFTER_EN = 3;
	localparam int BIT_POST_EN  = 4;
	localparam int ST_CH_LSB    = 0;
	localparam int ST_CHAIN_LSB = 2;
	localparam int ST_UNLOCK    = 5;
	localparam int ST_OUT_LSB   = 6;
	localparam int ST_LOADING   = 10;

	// ==========================================================
	// Engine and unlock constants
	localparam logic [POS_W-1:0]  CYCLE_CAT    = 16'h0B40;
	// Arbitrary token value
	localparam logic [DATA_W-1:0] UNLOCK_TOKEN = 32'h5A5A_C3C3;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {CH_IDLE, CH_MAIN, CH_ADLY, CH_AFTER, CH_PDLY, CH_POST} mfs_chain_t;

	typedef struct packed {
		logic             mainEn;
		logic             pilotEn;
		logic             preEn;
		logic             afterEn;
		logic             postEn;
		logic [POS_W-1:0] mainStart;
		logic [POS_W-1:0] pilotAdv;
		logic [POS_W-1:0] preAdv;
		logic [DUR_W-1:0] pilotDur;
		logic [DUR_W-1:0] preDur;
		logic [DUR_W-1:0] mainDur;
		logic [DLY_W-1:0] afterDly;
		logic [DUR_W-1:0] afterDur;
		logic [DLY_W-1:0] postDly;
		logic [DUR_W-1:0] postDur;
		logic [POS_W-1:0] switchAngle;
	} mfs_settings_t;

endpackage : mfs_pkg

// ===== hw/mfs_pulse_timer.sv
// Down counter that holds busy for exactly the loaded number of cycles
`timescale 1ns/1ps
module mfs_pulse_timer (
	input  wire logic mclk,
	input  wire logic rst,
	mfs_timer_if.tmr  tif
);
	typedef struct packed {
		logic [mfs_pkg::CNT_W-1:0] cnt;
		logic                      busy;
		logic                      done;
	} mfs_tmr_state_t;

	mfs_tmr_state_t st_ff;
	mfs_tmr_state_t nxt_st;

	// ==========================================================
	// Counting
	// A zero load gives no busy cycle but still one done pulse
	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		if (tif.abort) begin
			nxt_st.busy = 1'b0;
			nxt_st.cnt  = '0;
		end else if (tif.load) begin
			nxt_st.cnt  = tif.value;
			nxt_st.busy = (tif.value != '0);
			nxt_st.done = (tif.value == '0);
		end else if (st_ff.busy) begin
			if (st_ff.cnt == 24'h000001) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end
			nxt_st.cnt = st_ff.cnt - 24'h000001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tif.busy = st_ff.busy;
	assign tif.done = st_ff.done;
endmodule : mfs_pulse_timer

// ===== hw/mfs_scheduler.sv
// Four-channel time-multiplexed multi-pulse fuel command scheduler
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mfs_scheduler (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [mfs_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [mfs_pkg::DATA_W-1:0]  pwdata,
	output logic      [mfs_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [mfs_pkg::POS_W-1:0]   enginePos,
	input  wire logic                        enginePosValid,
	input  wire logic [mfs_pkg::DATA_W-1:0]  unlockToken,
	output logic                             channelSwitchStrobe,
	output logic                             pulseOutCh1,
	output logic                             pulseOutCh2,
	output logic                             pulseOutCh3,
	output logic                             pulseOutCh4
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [mfs_pkg::CH_W-1:0]   cur;
		mfs_pkg::mfs_settings_t     set;
		mfs_pkg::mfs_chain_t        chain;
		logic                       armPilot;
		logic                       armPre;
		logic                       armMain;
		logic                       armSwitch;
		logic                       reloadReq;
		logic                       ldActive;
		logic [mfs_pkg::IDX_W-1:0]  ldIdx;
		logic                       rdIssued;
		logic                       strobe;
		logic [mfs_pkg::NUM_CH-1:0] pulseOut;
	} mfs_sched_state_t;

	mfs_sched_state_t st_ff;
	mfs_sched_state_t nxt_st;

	logic [mfs_pkg::NUM_TMR-1:0] tLoad;
	logic [mfs_pkg::CNT_W-1:0]   tVal [mfs_pkg::NUM_TMR];
	logic                        tAbort;
	logic [mfs_pkg::NUM_TMR-1:0] tBusy;
	logic [mfs_pkg::NUM_TMR-1:0] tDone;

	logic                        memWe;
	logic                        memRe;
	logic [mfs_pkg::MEM_AW-1:0]  memRaddr;
	logic [mfs_pkg::DATA_W-1:0]  memRdata;

	logic                        unlocked;
	logic                        apbAccess;
	logic                        isChanWord;
	logic                        isStatus;
	logic [mfs_pkg::POS_W-1:0]   pilotTgt;
	logic [mfs_pkg::POS_W-1:0]   preTgt;
	logic                        canFire;
	logic [mfs_pkg::DATA_W-1:0]  statusWord;
	logic                        pilotOn;
	logic                        preOn;
	logic                        chainOn;
	logic                        anyOn;

	// ==========================================================
	// Helpers
	// Advance is positional and wraps through the end of the engine cycle
	function automatic logic [mfs_pkg::POS_W-1:0] angleBefore(
		input logic [mfs_pkg::POS_W-1:0] start,
		input logic [mfs_pkg::POS_W-1:0] adv
	);
		logic [mfs_pkg::POS_W:0] sum;
		sum = {1'b0, start} + {1'b0, mfs_pkg::CYCLE_CAT} - {1'b0, adv};
		if (start >= adv) begin
			return start - adv;
		end
		return sum[mfs_pkg::POS_W-1:0];
	endfunction : angleBefore

	// Only the documented width of each field is kept, so larger values wrap
	function automatic mfs_pkg::mfs_settings_t putWord(
		input mfs_pkg::mfs_settings_t    s,
		input logic [mfs_pkg::IDX_W-1:0] idx,
		input logic [mfs_pkg::DATA_W-1:0] w
	);
		mfs_pkg::mfs_settings_t r;
		r = s;
		case (idx)
			mfs_pkg::IDX_CTRL: begin
				r.mainEn  = w[mfs_pkg::BIT_MAIN_EN];
				r.pilotEn = w[mfs_pkg::BIT_PILOT_EN];
				r.preEn   = w[mfs_pkg::BIT_PRE_EN];
				r.afterEn = w[mfs_pkg::BIT_AFTER_EN];
				r.postEn  = w[mfs_pkg::BIT_POST_EN];
			end
			mfs_pkg::IDX_MAIN_ANG:  r.mainStart   = w[mfs_pkg::POS_W-1:0];
			mfs_pkg::IDX_PILOT_ADV: r.pilotAdv    = w[mfs_pkg::POS_W-1:0];
			mfs_pkg::IDX_PRE_ADV:   r.preAdv      = w[mfs_pkg::POS_W-1:0];
			mfs_pkg::IDX_PILOT_DUR: r.pilotDur    = w[mfs_pkg::DUR_W-1:0];
			mfs_pkg::IDX_PRE_DUR:   r.preDur      = w[mfs_pkg::DUR_W-1:0];
			mfs_pkg::IDX_MAIN_DUR:  r.mainDur     = w[mfs_pkg::DUR_W-1:0];
			mfs_pkg::IDX_AFTER_DLY: r.afterDly    = w[mfs_pkg::DLY_W-1:0];
			mfs_pkg::IDX_AFTER_DUR: r.afterDur    = w[mfs_pkg::DUR_W-1:0];
			mfs_pkg::IDX_POST_DLY:  r.postDly     = w[mfs_pkg::DLY_W-1:0];
			mfs_pkg::IDX_POST_DUR:  r.postDur     = w[mfs_pkg::DUR_W-1:0];
			mfs_pkg::IDX_SWITCH:    r.switchAngle = w[mfs_pkg::POS_W-1:0];
			default:                r = s;
		endcase
		return r;
	endfunction : putWord

	// ==========================================================
	// Pulse timers: pilot, pre, then main chain
	mfs_timer_if tmrIf [mfs_pkg::NUM_TMR] ();

	for (genvar g = 0; g < mfs_pkg::NUM_TMR; g++) begin : gTmr
		assign tmrIf[g].load  = tLoad[g];
		assign tmrIf[g].value = tVal[g];
		assign tmrIf[g].abort = tAbort;
		assign tBusy[g]       = tmrIf[g].busy;
		assign tDone[g]       = tmrIf[g].done;
		mfs_pulse_timer uTmr (
			.mclk (mclk),
			.rst  (rst),
			.tif  (tmrIf[g])
		);
	end

	// ==========================================================
	// Settings store
	mfs_cfg_mem uMem (
		.mclk  (mclk),
		.rst   (rst),
		.we    (memWe),
		.waddr (paddr[7:2]),
		.wdata (pwdata),
		.re    (memRe),
		.raddr (memRaddr),
		.rdata (memRdata)
	);

	// ==========================================================
	// Decode and derived terms
	assign unlocked   = (unlockToken == mfs_pkg::UNLOCK_TOKEN);
	assign apbAccess  = psel && penable;
	assign isChanWord = (paddr[11:8] == 4'h0) && (paddr[5:2] < mfs_pkg::IDX_COUNT);
	assign isStatus   = (paddr[11:2] == mfs_pkg::STATUS_OFS[11:2]);
	assign pilotTgt   = angleBefore(st_ff.set.mainStart, st_ff.set.pilotAdv);
	assign preTgt     = angleBefore(st_ff.set.mainStart, st_ff.set.preAdv);
	// No position-triggered pulse or switch fires on stale settings while a channel is being loaded
	assign canFire    = enginePosValid && !st_ff.ldActive && !st_ff.reloadReq;

	always_comb begin
		statusWord = mfs_pkg::RST_WORD;
		statusWord[mfs_pkg::ST_CH_LSB +: mfs_pkg::CH_W]    = st_ff.cur;
		statusWord[mfs_pkg::ST_CHAIN_LSB +: 3]             = st_ff.chain;
		statusWord[mfs_pkg::ST_UNLOCK]                     = unlocked;
		statusWord[mfs_pkg::ST_OUT_LSB +: mfs_pkg::NUM_CH] = st_ff.pulseOut;
		statusWord[mfs_pkg::ST_LOADING]                    = st_ff.ldActive;
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic apbIssue;
		logic ldRead;
		apbIssue = 1'b0;
		ldRead   = 1'b0;
		nxt_st   = st_ff;
		nxt_st.strobe = 1'b0;
		tLoad    = '0;
		tAbort   = 1'b0;
		for (int i = 0; i < mfs_pkg::NUM_TMR; i++) begin
			tVal[i] = '0;
		end
		memWe    = 1'b0;
		pready   = 1'b0;
		pslverr  = 1'b0;
		prdata   = mfs_pkg::RST_WORD;

		// Register bus: writes and status answer at once, words one cycle later, or after a running load finishes
		if (apbAccess) begin
			if (!isChanWord && !isStatus) begin
				pready  = 1'b1;
				pslverr = 1'b1;
			end else if (pwrite) begin
				pready = 1'b1;
				if (isChanWord) begin
					memWe = 1'b1;
					if (paddr[7:6] == st_ff.cur) begin
						nxt_st.reloadReq = 1'b1;
					end
				end
			end else if (isStatus) begin
				pready = 1'b1;
				prdata = statusWord;
			end else if (st_ff.rdIssued) begin
				pready          = 1'b1;
				prdata          = memRdata;
				nxt_st.rdIssued = 1'b0;
			end else if (!st_ff.ldActive) begin
				apbIssue        = 1'b1;
				nxt_st.rdIssued = 1'b1;
			end
		end

		// Loader: copies the active channel's words into the engine
		if (st_ff.ldActive) begin
			ldRead = (st_ff.ldIdx < mfs_pkg::IDX_COUNT);
			if (st_ff.ldIdx != 4'h0) begin
				nxt_st.set = putWord(st_ff.set, st_ff.ldIdx - 4'h1, memRdata);
			end
			if (st_ff.ldIdx == mfs_pkg::IDX_COUNT) begin
				nxt_st.ldActive = 1'b0;
			end
			nxt_st.ldIdx = st_ff.ldIdx + 4'h1;
		end else if (st_ff.reloadReq && !apbIssue && !st_ff.rdIssued) begin
			nxt_st.ldActive  = 1'b1;
			nxt_st.ldIdx     = 4'h0;
			// A write to the active channel in this same cycle still asks again
			nxt_st.reloadReq = memWe && (paddr[7:6] == st_ff.cur);
		end
		memRe    = ldRead || apbIssue;
		memRaddr = ldRead ? {st_ff.cur, st_ff.ldIdx} : paddr[7:2];

		// Early pulses placed by position ahead of the main start
		if (canFire && st_ff.armPilot && enginePos == pilotTgt) begin
			nxt_st.armPilot = 1'b0;
			tLoad[0]        = st_ff.set.mainEn && st_ff.set.pilotEn;
			tVal[0]         = {6'h00, st_ff.set.pilotDur};
		end
		if (canFire && st_ff.armPre && enginePos == preTgt) begin
			nxt_st.armPre = 1'b0;
			tLoad[1]      = st_ff.set.mainEn && st_ff.set.preEn;
			tVal[1]       = {6'h00, st_ff.set.preDur};
		end

		// Main chain: main, after delay, after, post delay, post
		case (st_ff.chain)
			mfs_pkg::CH_IDLE: begin
				if (canFire && st_ff.armMain && enginePos == st_ff.set.mainStart) begin
					nxt_st.armMain = 1'b0;
					if (st_ff.set.mainEn) begin
						tLoad[2]     = 1'b1;
						tVal[2]      = {6'h00, st_ff.set.mainDur};
						nxt_st.chain = mfs_pkg::CH_MAIN;
					end
				end
			end
			mfs_pkg::CH_MAIN: begin
				if (tDone[2]) begin
					if (st_ff.set.afterEn) begin
						tLoad[2]     = 1'b1;
						tVal[2]      = st_ff.set.afterDly;
						nxt_st.chain = mfs_pkg::CH_ADLY;
					end else begin
						nxt_st.chain = mfs_pkg::CH_IDLE;
					end
				end
			end
			mfs_pkg::CH_ADLY: begin
				if (tDone[2]) begin
					tLoad[2]     = 1'b1;
					tVal[2]      = {6'h00, st_ff.set.afterDur};
					nxt_st.chain = mfs_pkg::CH_AFTER;
				end
			end
			mfs_pkg::CH_AFTER: begin
				if (tDone[2]) begin
					if (st_ff.set.postEn && st_ff.set.afterEn) begin
						tLoad[2]     = 1'b1;
						tVal[2]      = st_ff.set.postDly;
						nxt_st.chain = mfs_pkg::CH_PDLY;
					end else begin
						nxt_st.chain = mfs_pkg::CH_IDLE;
					end
				end
			end
			mfs_pkg::CH_PDLY: begin
				if (tDone[2]) begin
					tLoad[2]     = 1'b1;
					tVal[2]      = {6'h00, st_ff.set.postDur};
					nxt_st.chain = mfs_pkg::CH_POST;
				end
			end
			mfs_pkg::CH_POST: begin
				if (tDone[2]) begin
					nxt_st.chain = mfs_pkg::CH_IDLE;
				end
			end
			default: begin
				nxt_st.chain = mfs_pkg::CH_IDLE;
			end
		endcase

		// Channel switch: pulses still running are cut, which is why the
		// switch angle has to sit well after the last pulse
		if (canFire && st_ff.armSwitch && enginePos == st_ff.set.switchAngle) begin
			nxt_st.strobe    = 1'b1;
			nxt_st.cur       = st_ff.cur + 2'h1;
			tAbort           = 1'b1;
			tLoad            = '0;
			nxt_st.chain     = mfs_pkg::CH_IDLE;
			nxt_st.armPilot  = 1'b1;
			nxt_st.armPre    = 1'b1;
			nxt_st.armMain   = 1'b1;
			nxt_st.reloadReq = 1'b1;
		end

		// Output stage: only the active channel's output can be high
		pilotOn = tBusy[0] && st_ff.set.mainEn && st_ff.set.pilotEn;
		preOn   = tBusy[1] && st_ff.set.mainEn && st_ff.set.preEn;
		chainOn = tBusy[2] && st_ff.set.mainEn &&
			((st_ff.chain == mfs_pkg::CH_MAIN) ||
			 (st_ff.chain == mfs_pkg::CH_AFTER && st_ff.set.afterEn) ||
			 (st_ff.chain == mfs_pkg::CH_POST && st_ff.set.afterEn && st_ff.set.postEn));
		anyOn   = pilotOn || preOn || chainOn;
		for (int c = 0; c < mfs_pkg::NUM_CH; c++) begin
			nxt_st.pulseOut[c] = unlocked && anyOn && (st_ff.cur == c[1:0]);
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff           <= '0;
			st_ff.chain     <= mfs_pkg::CH_IDLE;
			st_ff.armPilot  <= 1'b1;
			st_ff.armPre    <= 1'b1;
			st_ff.armMain   <= 1'b1;
			st_ff.armSwitch <= 1'b1;
			st_ff.reloadReq <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign channelSwitchStrobe = st_ff.strobe;
	assign pulseOutCh1         = st_ff.pulseOut[0];
	assign pulseOutCh2         = st_ff.pulseOut[1];
	assign pulseOutCh3         = st_ff.pulseOut[2];
	assign pulseOutCh4         = st_ff.pulseOut[3];
endmodule : mfs_scheduler

// ===== hw/mfs_timer_if.sv
// Control bundle between the scheduler and one pulse timer
`timescale 1ns/1ps
interface mfs_timer_if;
	logic                     load;
	logic                     abort;
	logic [mfs_pkg::CNT_W-1:0] value;
	logic                     busy;
	logic                     done;
	modport ctrl (output load, output abort, output value, input busy, input done);
	modport tmr  (input load, input abort, input value, output busy, output done);
endinterface : mfs_timer_if
